//--- cwd_watchdog.sv
// Crystal clocked watchdog with protected control register
//
// Summary of operation
// R1: Timeout lasts two to the prescale times 512 crystal periods.
// R2: Codes 0 to 7 give 15.6 ms to 2000 ms, ending reset or interrupt.
// R3: Code 8 resets at once; higher codes are reserved, never selected.
// R4: Every watchdog timeout sets the timeout flag.
// R5: Flag clears on software writing 0 or on hardware reset.
// R6: A watchdog reset leaves the timeout flag set.
// R7: Writing 1 to run enables and restarts the counters; refreshes it.
// R8: Without refresh in the period, reset or interrupt per response select.
// R9: Run bit clears on watchdog reset with reset response, and hardware reset.
// R10: Interrupt response makes it a periodic timer at the prescale period.
// R11: Writes take effect only after the unlock bit was set.
// R12: Software masks global interrupts before the unlock sequence.
// R13: The register write must be the instruction right after the unlock.
// R14: Control register at C0H, bit addressable, resets to 10H.
// R15: The counter advances on crystal ticks, not the core clock.
// R16: Unprotected writes are ignored; unlock expires after next instruction.
`timescale 1ns/1ps
`default_nettype none

module cwd_watchdog
  import cwd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire cwd_sfr_wr_t sfr_wr,
  input  wire logic        instr_end,
  input  wire logic        xtal_tick,
  output logic [7:0]       watchdog_control_reg,
  output logic             wd_reset_req,
  output logic             wd_irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Last count of the period for a prescale code
  function automatic logic [CWD_CNT_W-1:0] cwd_term(input logic [3:0] pre);
    logic [CWD_CNT_W:0] full;
    full = ({{CWD_CNT_W{1'b0}}, 1'b1} << (CWD_BASE_SHIFT + int'(pre[2:0])));
    return full[CWD_CNT_W-1:0] - {{(CWD_CNT_W-1){1'b0}}, 1'b1};
  endfunction

  // Value a write leaves on one bit: byte data or the addressed bit
  function automatic logic cwd_wbit(input cwd_sfr_wr_t w, input int idx);
    logic v;
    v = 1'b0;
    if (w.byte_wr)
      v = w.data[idx];
    else if (int'(w.bit_idx) == idx)
      v = w.data[0];
    return v;
  endfunction

  // Whether a write touches one bit
  function automatic logic cwd_hits(input cwd_sfr_wr_t w, input int idx);
    return w.byte_wr || (w.bit_wr && int'(w.bit_idx) == idx);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0]           pre_reg,   pre_next;
  logic                 irsel_reg, irsel_next;
  logic                 flag_reg,  flag_next;
  logic                 run_reg,   run_next;
  cwd_unlock_t          ul_reg,    ul_next;
  logic [CWD_CNT_W-1:0] cnt_reg,   cnt_next;
  logic                 rst_reg,   rst_next;
  logic                 irq_reg,   irq_next;

  logic wr_hit;
  logic wr_ok;
  logic expire;
  logic now_reset;

  assign wr_hit = (sfr_wr.byte_wr || sfr_wr.bit_wr)
                  && (sfr_wr.addr == CWD_CTRL_ADDR);
  // Only the instruction after the unlock may change the register
  assign wr_ok  = wr_hit && (ul_reg == CWD_UL_OPEN); // R11 R13 R16

  // Period end; a prescale shortened by a bit write expires at the next
  // tick instead of waiting for a wrap. Reserved codes never time out
  assign expire    = run_reg && !pre_reg[3] && xtal_tick
                     && (cnt_reg >= cwd_term(pre_reg)); // R1 R2 R15
  assign now_reset = run_reg && (pre_reg == CWD_PRE_NOW); // R3

  // ----------------------------------------------------------------
  // Unlock sequencing
  // ----------------------------------------------------------------
  // Armed in the setting instruction, open for exactly the next one;
  // a setting write in its instruction's last cycle opens at once
  always_comb
  begin
    ul_next = ul_reg;
    case (ul_reg)
      CWD_UL_IDLE:
        if (wr_hit && cwd_hits(sfr_wr, CWD_UNLOCK_BIT)
            && cwd_wbit(sfr_wr, CWD_UNLOCK_BIT))
          ul_next = instr_end ? CWD_UL_OPEN : CWD_UL_ARMED; // R13
      CWD_UL_ARMED:
        if (instr_end)
          ul_next = CWD_UL_OPEN;
      CWD_UL_OPEN:
        if (wr_ok || instr_end)
          ul_next = CWD_UL_IDLE; // R16
      default:
        ul_next = CWD_UL_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Control fields, counter and events
  // ----------------------------------------------------------------
  // Timeout wins over a same-cycle software clear of the flag
  always_comb
  begin
    pre_next   = pre_reg;
    irsel_next = irsel_reg;
    flag_next  = flag_reg;
    run_next   = run_reg;
    cnt_next   = cnt_reg;
    rst_next   = 1'b0;
    irq_next   = 1'b0;
    if (run_reg && xtal_tick)
      cnt_next = cnt_reg + {{(CWD_CNT_W-1){1'b0}}, 1'b1}; // R15
    if (wr_ok)
    begin
      if (cwd_hits(sfr_wr, CWD_PRE_LSB))
        pre_next[0] = cwd_wbit(sfr_wr, CWD_PRE_LSB);
      if (cwd_hits(sfr_wr, CWD_PRE_LSB + 1))
        pre_next[1] = cwd_wbit(sfr_wr, CWD_PRE_LSB + 1);
      if (cwd_hits(sfr_wr, CWD_PRE_LSB + 2))
        pre_next[2] = cwd_wbit(sfr_wr, CWD_PRE_LSB + 2);
      if (cwd_hits(sfr_wr, CWD_PRE_MSB))
        pre_next[3] = cwd_wbit(sfr_wr, CWD_PRE_MSB);
      if (cwd_hits(sfr_wr, CWD_IRSEL_BIT))
        irsel_next = cwd_wbit(sfr_wr, CWD_IRSEL_BIT);
      if (cwd_hits(sfr_wr, CWD_FLAG_BIT) && !cwd_wbit(sfr_wr, CWD_FLAG_BIT))
        flag_next = 1'b0; // R5
      if (cwd_hits(sfr_wr, CWD_RUN_BIT))
      begin
        run_next = cwd_wbit(sfr_wr, CWD_RUN_BIT);
        if (run_next)
          cnt_next = '0; // R7
      end
    end
    if (expire)
    begin
      flag_next = 1'b1; // R4
      cnt_next  = '0;
      if (irsel_reg)
        irq_next = 1'b1; // R8 R10
      else
      begin
        rst_next = 1'b1; // R8
        run_next = 1'b0; // R9
      end
    end
    else if (now_reset)
    begin
      flag_next = 1'b1; // R3 R4 R6
      rst_next  = 1'b1;
      run_next  = 1'b0; // R9
      cnt_next  = '0;
    end
  end

  // Hardware reset restores the power-on image and clears the flag
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_reg   <= CWD_CTRL_RESET[CWD_PRE_MSB:CWD_PRE_LSB]; // R14
      irsel_reg <= CWD_CTRL_RESET[CWD_IRSEL_BIT];
      flag_reg  <= 1'b0; // R5
      run_reg   <= 1'b0; // R9
      ul_reg    <= CWD_UL_IDLE;
      cnt_reg   <= '0;
      rst_reg   <= 1'b0;
      irq_reg   <= 1'b0;
    end
    else
    begin
      pre_reg   <= pre_next;
      irsel_reg <= irsel_next;
      flag_reg  <= flag_next;
      run_reg   <= run_next;
      ul_reg    <= ul_next;
      cnt_reg   <= cnt_next;
      rst_reg   <= rst_next;
      irq_reg   <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The watchdog reset request must not reach this block's rst_n,
  // otherwise the flag could not survive it
  assign watchdog_control_reg = {pre_reg, irsel_reg, flag_reg, run_reg,
                                 ul_reg != CWD_UL_IDLE}; // R14
  assign wd_reset_req = rst_reg;
  assign wd_irq       = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_unlock_then_end;
    (ul_reg == CWD_UL_ARMED) && instr_end;
  endsequence

  sequence s_closed_write;
    wr_hit && (ul_reg != CWD_UL_OPEN) && !expire && !now_reset;
  endsequence

  chk_period_end: assert property ( // R1
    run_reg && !pre_reg[3] && xtal_tick && cnt_reg == cwd_term(pre_reg)
    |=> flag_reg && cnt_reg == '0)
    else $error("No timeout at period end");
  chk_flag_set: assert property ( // R4
    (expire || now_reset) |=> flag_reg)
    else $error("Timeout did not set flag");
  chk_flag_clear: assert property ( // R5
    wr_ok && sfr_wr.byte_wr && !sfr_wr.data[CWD_FLAG_BIT]
    && !expire && !now_reset |=> !flag_reg)
    else $error("Flag not cleared by write of zero");
  chk_reset_keeps: assert property ( // R6 R9
    (expire && !irsel_reg) || now_reset |=> wd_reset_req && flag_reg
    && !run_reg)
    else $error("Watchdog reset handling wrong");
  chk_refresh: assert property ( // R7
    wr_ok && sfr_wr.byte_wr && sfr_wr.data[CWD_RUN_BIT] && !expire
    && !now_reset |=> run_reg && cnt_reg == '0)
    else $error("Refresh did not restart counter");
  chk_irq_mode: assert property ( // R10
    expire && irsel_reg |=> wd_irq && !wd_reset_req && run_reg
    && cnt_reg == '0)
    else $error("Interrupt response wrong");
  chk_immediate: assert property ( // R3
    run_reg && pre_reg == CWD_PRE_NOW |=> wd_reset_req)
    else $error("Code 8 did not reset at once");
  chk_locked_write: assert property ( // R11 R16
    s_closed_write |=> pre_reg == $past(pre_reg)
    && irsel_reg == $past(irsel_reg))
    else $error("Write accepted without unlock");
  chk_unlock_window: assert property ( // R13 R16
    s_unlock_then_end ##1 (instr_end && !wr_hit) |=> ul_reg == CWD_UL_IDLE)
    else $error("Unlock outlived next instruction");
  chk_no_tick_hold: assert property ( // R15
    !xtal_tick && !wr_ok && !expire && !now_reset |=> $stable(cnt_reg))
    else $error("Counter moved without crystal tick");

endmodule

`default_nettype wire

//--- cwd_pkg.sv
// Constants, field layout and carrier types for the crystal clocked watchdog
`default_nettype none

package cwd_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CWD_CTRL_ADDR  = 8'hc0; // Bit addressable
  localparam logic [7:0] CWD_CTRL_RESET = 8'h10;
  localparam int         CWD_PRE_LSB    = 4;
  localparam int         CWD_PRE_MSB    = 7;
  localparam int         CWD_IRSEL_BIT  = 3;
  localparam int         CWD_FLAG_BIT   = 2;
  localparam int         CWD_RUN_BIT    = 1;
  localparam int         CWD_UNLOCK_BIT = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CWD_XTAL_HZ    = 32768; // Crystal rate
  localparam int         CWD_BASE_SHIFT = 9;     // 2^9 crystal periods
  localparam int         CWD_PRE_MAX    = 7;     // Longest timed code
  localparam logic [3:0] CWD_PRE_NOW    = 4'h8;  // Immediate reset code
  localparam int         CWD_CNT_W      = CWD_BASE_SHIFT + CWD_PRE_MAX;

  // ----------------------------------------------------------------
  // Special function register access from the core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       byte_wr;  // Whole byte write, one-cycle pulse
    logic       bit_wr;   // Single bit write, one-cycle pulse
    logic [7:0] addr;     // Register address (bit ops: byte address)
    logic [2:0] bit_idx;  // Bit number for bit_wr
    logic [7:0] data;     // Byte data; data[0] is the bit value
  } cwd_sfr_wr_t;

  typedef enum logic [1:0] {
    CWD_UL_IDLE,
    CWD_UL_ARMED,
    CWD_UL_OPEN
  } cwd_unlock_t;

endpackage

`default_nettype wire

//--- cwd_watchdog_bench.sv
// Self-checking bench for the crystal clocked watchdog
`timescale 1ns/1ps
`default_nettype none

module cwd_watchdog_bench import cwd_pkg::*;;

  logic        clk_sys;
  logic        rst_n;
  cwd_sfr_wr_t sfr_wr;
  logic        instr_end;
  logic        xtal_tick;
  logic [7:0]  ctrl;
  logic        rst_req;
  logic        irq;
  int          n_errors;
  int          check_count;
  int          n_rst;
  int          n_irq;

  cwd_watchdog u_dut (
    .clk_sys              (clk_sys),
    .rst_n                (rst_n),
    .sfr_wr               (sfr_wr),
    .instr_end            (instr_end),
    .xtal_tick            (xtal_tick),
    .watchdog_control_reg (ctrl),
    .wd_reset_req         (rst_req),
    .wd_irq               (irq)
  );

  // ----------------------------------------------------------------
  // Clock and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One register write, launched and released on falling edges
  task automatic sfr(input logic is_bit, input logic [2:0] idx,
                     input logic [7:0] d);
    @(negedge clk_sys);
    sfr_wr = '{byte_wr: ~is_bit, bit_wr: is_bit, addr: CWD_CTRL_ADDR,
               bit_idx: idx, data: d};
    @(negedge clk_sys);
    sfr_wr = '0;
  endtask

  // Arm the unlock bit, then end that instruction
  task automatic unlock();
    sfr(1'b1, 3'h0, 8'h01);
    instr_end = 1'b1;
    @(negedge clk_sys);
    instr_end = 1'b0;
  endtask

  // Nothing runs between unlock and write, as with interrupts masked
  task automatic prot_write(input logic [7:0] v);
    unlock();
    sfr(1'b0, 3'h0, v);
  endtask

  // Crystal ticks on consecutive cycles; pulses are counted as they land
  task automatic ticks(input int n);
    n_rst = 0;
    n_irq = 0;
    xtal_tick = 1'b1;
    repeat (n)
    begin
      @(negedge clk_sys);
      if (rst_req === 1'b1) n_rst++;
      if (irq === 1'b1) n_irq++;
    end
    xtal_tick = 1'b0;
    // One idle edge so a following call never re-raises the tick at once
    @(negedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_locked();
    check(ctrl, CWD_CTRL_RESET, "reset value");
    sfr(1'b0, 3'h0, 8'h72);
    check(ctrl, 8'h10, "write without unlock");
    sfr(1'b1, 3'h0, 8'h01);
    // Two instructions end back to back; the second carries no write
    instr_end = 1'b1;
    @(negedge clk_sys);
    check(ctrl, 8'h11, "unlock armed");
    @(negedge clk_sys);
    instr_end = 1'b0;
    sfr(1'b0, 3'h0, 8'h72);
    check(ctrl, 8'h10, "late write");
  endtask

  task automatic t_refresh();
    prot_write(8'h02);
    check(ctrl, 8'h02, "enable");
    ticks(300);
    unlock();
    sfr(1'b1, 3'h1, 8'h01);
    ticks(511);
    check(n_rst[7:0], 8'h00, "early reset");
    ticks(1);
    check(n_rst[7:0], 8'h01, "timeout reset");
    check(ctrl, 8'h04, "after watchdog reset");
    prot_write(8'h00);
    check(ctrl, 8'h00, "flag cleared");
  endtask

  // Interrupt response repeats every period for several prescales
  task automatic t_timer();
    for (int p = 0; p < 5; p++)
    begin
      prot_write({p[3:0], 4'ha});
      ticks((512 << p) - 1);
      check(n_irq[7:0], 8'h00, "early irq");
      ticks(1);
      check(n_irq[7:0], 8'h01, "irq at period");
      check(ctrl, {p[3:0], 4'he}, "flag set, run kept");
      ticks(512 << p);
      check(n_irq[7:0], 8'h01, "second period");
      check(n_rst[7:0], 8'h00, "no reset in timer mode");
    end
  endtask

  task automatic t_immediate();
    bit seen;
    seen = 1'b0;
    prot_write(8'h82);
    for (int i = 0; i < 4 && !seen; i++)
    begin
      if (rst_req === 1'b1) seen = 1'b1;
      else @(negedge clk_sys);
    end
    check({7'h0, seen}, 8'h01, "immediate reset");
    @(negedge clk_sys);
    check(ctrl, 8'h84, "run cleared, flag kept");
    check({7'h0, rst_req}, 8'h00, "reset pulse ended");
    // Arming write in the last cycle of its own instruction
    @(negedge clk_sys);
    sfr_wr = '{byte_wr: 1'b0, bit_wr: 1'b1, addr: CWD_CTRL_ADDR,
               bit_idx: 3'h0, data: 8'h01};
    instr_end = 1'b1;
    @(negedge clk_sys);
    sfr_wr = '0;
    instr_end = 1'b0;
    // Run set with a one in the flag: the flag must survive the write
    sfr(1'b0, 3'h0, 8'h06);
    check(ctrl, 8'h06, "same-cycle unlock, flag kept");
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    check(ctrl, 8'h10, "hardware reset");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    sfr_wr = '0;
    instr_end = 1'b0;
    xtal_tick = 1'b0;
    rst_n = 1'b0;
    n_errors = 0;
    check_count = 0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    t_locked();
    t_refresh();
    t_timer();
    t_immediate();
    final_report();
  end

  initial
  begin
    #300000;
    n_errors++;
    $display("unexpected at %0t: run did not complete", $time);
    final_report();
  end

endmodule

`default_nettype wire
